// ===== pfc_defines.svh
// Timing counts and command codes for the parallel flash host controller.
// Assumes a 250 MHz i_clk; included by the controller only, not by the package.
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH
// ==========================================
// Clock and bus timing
`define PFC_CLK_PERIOD_NS 4
`define PFC_ACCESS_NS 70
`define PFC_ACCESS_CYC ((`PFC_ACCESS_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_WE_LOW_NS 40
`define PFC_WE_LOW_CYC ((`PFC_WE_LOW_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_HV_PULSE_NS 400
`define PFC_HV_PULSE_CYC ((`PFC_HV_PULSE_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_GAP_CYC 2
// ==========================================
// Command bytes and unlock addresses
`define PFC_CMD_RESET 8'hf0
`define PFC_CMD_UNLOCK1 8'haa
`define PFC_CMD_UNLOCK2 8'h55
`define PFC_CMD_ID 8'h90
`define PFC_CMD_PROG 8'ha0
`define PFC_CMD_ERASE 8'h80
`define PFC_CMD_CHIP 8'h10
`define PFC_CMD_SECT 8'h30
`define PFC_CMD_SUSP 8'hb0
`define PFC_CMD_RESUME 8'h30
`define PFC_ADDR_U1 19'h00555
`define PFC_ADDR_U2 19'h002aa
`define PFC_FAIL_BIT 5
`define PFC_SECT_MSB 18
`define PFC_SECT_LSB 16
`define PFC_PROT_SEL_BIT 6
`define PFC_ID_MODE_BIT 1
`endif

// ===== pfc_pkg.sv
// Types shared by the parallel flash host controller.
// Uses no macros from pfc_defines.svh.
package pfc_pkg;
  // ==========================================
  // Host operations
  typedef enum logic [3:0] {
    PFC_OP_READ,
    PFC_OP_RESET,
    PFC_OP_PROG,
    PFC_OP_CHIP_ERASE,
    PFC_OP_SECT_ERASE,
    PFC_OP_SUSPEND,
    PFC_OP_RESUME,
    PFC_OP_ID_ENTER,
    PFC_OP_HV_PROTECT,
    PFC_OP_HV_UNPROTECT,
    PFC_OP_HV_VERIFY,
    PFC_OP_HV_ID
  } pfc_op_t;
  typedef struct packed {
    pfc_op_t op;
    logic [18:0] addr;
    logic [7:0] data;
  } pfc_req_t;
  // Flash-facing control pins, all registered
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic hv_addr;
    logic hv_oe;
    logic [18:0] addr;
  } pfc_pins_t;
endpackage

// ===== pfc_ctrl.sv
// Host-side controller driving a byte-wide asynchronous parallel flash.
// Assumes flash pins are sampled synchronously; HV switches are external.
// What this block does
// - Command cycle: write and chip select low, output enable held high.
// - Only defined command sequences are ever written; others flagged as error.
// - Read: select and output enable low, byte sampled after access time.
// - Failure bit or ID mode needs reset command before array reads; block neither sends it nor holds reads, host issues PFC_OP_RESET.
// - Protect: high voltage on address pin and output enable, select low.
// - Host should protect all sectors before chip unprotect.
`timescale 1ns/10ps
`include "pfc_defines.svh"
module pfc_ctrl #(
  parameter int ACCESS_CYC = `PFC_ACCESS_CYC,
  parameter int WE_LOW_CYC = `PFC_WE_LOW_CYC,
  parameter int HV_PULSE_CYC = `PFC_HV_PULSE_CYC,
  parameter int SUSPEND_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_req_valid,
  input wire pfc_pkg::pfc_req_t i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  output logic o_rsp_fail,
  output logic o_cmd_error,
  output pfc_pkg::pfc_pins_t o_pins,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe
);
  typedef enum logic [2:0] {
    PFC_IDLE,
    PFC_SETUP,
    PFC_STROBE,
    PFC_HOLD,
    PFC_READ,
    PFC_WAIT
  } pfc_st_t;
  localparam int CW = 16;
  localparam logic [2:0] CYC_NONE = 3'h0;

  // ==========================================
  // State
  pfc_st_t st_reg, st_next;
  pfc_pkg::pfc_req_t req_reg, req_next;
  pfc_pkg::pfc_pins_t pins_reg, pins_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [2:0] idx_reg, idx_next;
  logic [2:0] ncyc_reg, ncyc_next;
  logic [7:0] dq_reg, dq_next;
  logic dq_oe_reg, dq_oe_next;
  logic rv_reg, rv_next;
  logic [7:0] rd_reg, rd_next;
  logic rf_reg, rf_next;
  logic err_reg, err_next;
  logic [7:0] prot_seen_reg, prot_seen_next;
  logic [18:0] ca;
  logic [7:0] cd;
  logic [2:0] ncyc;
  logic hv_op;

  // Number of bus cycles for each operation
  always_comb begin
    ncyc = CYC_NONE;
    hv_op = 1'b0;
    case (i_req.op)
      pfc_pkg::PFC_OP_RESET: ncyc = 3'h1;
      pfc_pkg::PFC_OP_SUSPEND: ncyc = 3'h1;
      pfc_pkg::PFC_OP_RESUME: ncyc = 3'h1;
      pfc_pkg::PFC_OP_ID_ENTER: ncyc = 3'h3;
      pfc_pkg::PFC_OP_PROG: ncyc = 3'h4;
      pfc_pkg::PFC_OP_CHIP_ERASE: ncyc = 3'h6;
      pfc_pkg::PFC_OP_SECT_ERASE: ncyc = 3'h6;
      pfc_pkg::PFC_OP_HV_PROTECT: hv_op = 1'b1;
      pfc_pkg::PFC_OP_HV_UNPROTECT: hv_op = 1'b1;
      default: ncyc = CYC_NONE;
    endcase
  end

  // Address and data of command cycle idx of the stored operation
  always_comb begin
    ca = `PFC_ADDR_U1;
    cd = `PFC_CMD_UNLOCK1;
    if (idx_reg == 3'h1 || idx_reg == 3'h4) begin
      ca = `PFC_ADDR_U2;
      cd = `PFC_CMD_UNLOCK2;
    end
    case (req_reg.op)
      pfc_pkg::PFC_OP_RESET: cd = `PFC_CMD_RESET;
      pfc_pkg::PFC_OP_SUSPEND: cd = `PFC_CMD_SUSP;
      pfc_pkg::PFC_OP_RESUME: cd = `PFC_CMD_RESUME;
      pfc_pkg::PFC_OP_ID_ENTER: if (idx_reg == 3'h2) cd = `PFC_CMD_ID;
      pfc_pkg::PFC_OP_PROG: begin
        if (idx_reg == 3'h2) cd = `PFC_CMD_PROG;
        if (idx_reg == 3'h3) begin
          ca = req_reg.addr;
          cd = req_reg.data;
        end
      end
      default: begin
        if (idx_reg == 3'h2) cd = `PFC_CMD_ERASE;
        if (idx_reg == 3'h5) begin
          // Sector erase addresses the sector by its top bits
          ca = (req_reg.op == pfc_pkg::PFC_OP_SECT_ERASE) ? req_reg.addr : `PFC_ADDR_U1;
          cd = (req_reg.op == pfc_pkg::PFC_OP_SECT_ERASE) ? `PFC_CMD_SECT : `PFC_CMD_CHIP;
        end
      end
    endcase
  end

  // ==========================================
  // Sequencer
  always_comb begin
    st_next = st_reg;
    req_next = req_reg;
    pins_next = pins_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    ncyc_next = ncyc_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    rv_next = 1'b0;
    rd_next = rd_reg;
    rf_next = rf_reg;
    err_next = 1'b0;
    prot_seen_next = prot_seen_reg;
    case (st_reg)
      PFC_IDLE: begin
        if (i_req_valid) begin
          req_next = i_req;
          ncyc_next = ncyc;
          idx_next = 3'h0;
          cnt_next = '0;
          pins_next.hv_addr = 1'b0;
          pins_next.hv_oe = 1'b0;
          if (i_req.op == pfc_pkg::PFC_OP_READ) begin
            pins_next.addr = i_req.addr;
            pins_next.ce_n = 1'b0;
            pins_next.oe_n = 1'b0;
            st_next = PFC_READ;
          end else if (i_req.op == pfc_pkg::PFC_OP_HV_VERIFY ||
                       i_req.op == pfc_pkg::PFC_OP_HV_ID) begin
            // HV reads: address pin at HV, protect select low
            pins_next.addr = i_req.addr;
            pins_next.addr[`PFC_PROT_SEL_BIT] = 1'b0;
            pins_next.addr[`PFC_ID_MODE_BIT] = (i_req.op == pfc_pkg::PFC_OP_HV_VERIFY);
            if (i_req.op == pfc_pkg::PFC_OP_HV_VERIFY) pins_next.addr[0] = 1'b0;
            pins_next.hv_addr = 1'b1;
            pins_next.ce_n = 1'b0;
            pins_next.oe_n = 1'b0;
            st_next = PFC_READ;
          end else if (i_req.op == pfc_pkg::PFC_OP_HV_UNPROTECT && prot_seen_reg != 8'hff) begin
            // Unprotect refused until all sectors protected
            err_next = 1'b1;
            rv_next = 1'b1;
          end else if (hv_op) begin
            if (i_req.op == pfc_pkg::PFC_OP_HV_PROTECT) begin
              prot_seen_next[i_req.addr[`PFC_SECT_MSB:`PFC_SECT_LSB]] = 1'b1;
            end else begin
              prot_seen_next = 8'h00;
            end
            pins_next.addr = i_req.addr;
            pins_next.addr[`PFC_PROT_SEL_BIT] = (i_req.op == pfc_pkg::PFC_OP_HV_UNPROTECT);
            pins_next.hv_addr = 1'b1;
            pins_next.hv_oe = 1'b1;
            pins_next.ce_n = 1'b0;
            st_next = PFC_SETUP;
          end else if (ncyc == CYC_NONE) begin
            err_next = 1'b1;
            rv_next = 1'b1;
          end else begin
            st_next = PFC_SETUP;
          end
        end
      end
      PFC_SETUP: begin
        // Address, select and data settle before WE falls
        if (!hv_op_reg()) begin
          pins_next.addr = ca;
          dq_next = cd;
          dq_oe_next = 1'b1;
          pins_next.ce_n = 1'b0;
          pins_next.oe_n = 1'b1;
        end
        st_next = PFC_STROBE;
      end
      PFC_STROBE: begin
        pins_next.we_n = 1'b0;
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CW'(hv_op_reg() ? HV_PULSE_CYC : WE_LOW_CYC)) begin
          pins_next.we_n = 1'b1;
          cnt_next = '0;
          st_next = PFC_HOLD;
        end
      end
      PFC_HOLD: begin
        // Data held one cycle past WE rise, then bus released
        pins_next.ce_n = 1'b1;
        dq_oe_next = 1'b0;
        pins_next.hv_addr = 1'b0;
        pins_next.hv_oe = 1'b0;
        idx_next = idx_reg + 1'b1;
        if (!hv_op_reg() && (idx_reg + 3'h1) != ncyc_reg) begin
          st_next = PFC_SETUP;
        end else begin
          st_next = PFC_WAIT;
        end
      end
      PFC_READ: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CW'(ACCESS_CYC)) begin
          rd_next = i_dq;
          rf_next = i_dq[`PFC_FAIL_BIT];
          pins_next.ce_n = 1'b1;
          pins_next.oe_n = 1'b1;
          pins_next.hv_addr = 1'b0;
          cnt_next = '0;
          st_next = PFC_WAIT;
        end
      end
      PFC_WAIT: begin
        cnt_next = cnt_reg + 1'b1;
        // Suspend latency covered before the next access
        if (cnt_reg == CW'((req_reg.op == pfc_pkg::PFC_OP_SUSPEND) ?
                           SUSPEND_CYC : `PFC_GAP_CYC)) begin
          cnt_next = '0;
          rv_next = 1'b1;
          st_next = PFC_IDLE;
        end
      end
      default: st_next = PFC_IDLE;
    endcase
  end

  function automatic logic hv_op_reg();
    return req_reg.op == pfc_pkg::PFC_OP_HV_PROTECT ||
           req_reg.op == pfc_pkg::PFC_OP_HV_UNPROTECT;
  endfunction

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Pins idle high: flash sits in array read after its own power-up
      st_reg <= PFC_IDLE;
      req_reg <= '0;
      pins_reg <= {1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 19'h00000};
      cnt_reg <= '0;
      idx_reg <= 3'h0;
      ncyc_reg <= 3'h0;
      dq_reg <= 8'h00;
      dq_oe_reg <= 1'b0;
      rv_reg <= 1'b0;
      rd_reg <= 8'h00;
      rf_reg <= 1'b0;
      err_reg <= 1'b0;
      prot_seen_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      req_reg <= req_next;
      pins_reg <= pins_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      ncyc_reg <= ncyc_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rf_reg <= rf_next;
      err_reg <= err_next;
      prot_seen_reg <= prot_seen_next;
    end
  end

  logic rdy_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) rdy_reg <= 1'b0;
    else rdy_reg <= (st_next == PFC_IDLE);
  end

  assign o_req_ready = rdy_reg;
  assign o_rsp_valid = rv_reg;
  assign o_rsp_data = rd_reg;
  assign o_rsp_fail = rf_reg;
  assign o_cmd_error = err_reg;
  assign o_pins = pins_reg;
  assign o_dq = dq_reg;
  assign o_dq_oe = dq_oe_reg;

  // ==========================================
  // Checks
  chk_we_oe_excl: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !pins_reg.we_n |-> pins_reg.oe_n && !pins_reg.ce_n)
    else $error("write strobe with output enable low");
  chk_dq_release: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dq_oe_reg |-> pins_reg.oe_n)
    else $error("host drives data while flash may drive");
  chk_addr_stable: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !pins_reg.we_n |-> $stable(pins_reg.addr))
    else $error("address moved during write strobe");
  chk_data_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(pins_reg.we_n) && !pins_reg.hv_addr |-> dq_oe_reg && $stable(dq_reg))
    else $error("data not held at write rise");
  chk_read_time: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(pins_reg.oe_n) |-> (pins_reg.oe_n == 1'b0) [*2])
    else $error("read strobe too short");
  chk_hv_setup: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pins_reg.hv_oe |-> pins_reg.hv_addr && !pins_reg.ce_n)
    else $error("hv oe without hv address");
  chk_err_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
    err_reg |-> rv_reg && !dq_oe_reg)
    else $error("bad op touched the bus");
  chk_seq_done: assert property (@(posedge i_clk) disable iff (!i_nrst)
    st_reg == PFC_WAIT && !hv_op_reg() && ncyc_reg != 3'h0 |-> idx_reg == ncyc_reg)
    else $error("command sequence cut short");
  cov_read: cover property (@(posedge i_clk) $fell(pins_reg.oe_n) ##[1:40] rv_reg);
  cov_prog: cover property (@(posedge i_clk)
    st_reg == PFC_HOLD && req_reg.op == pfc_pkg::PFC_OP_PROG && idx_reg == 3'h3);
  cov_hv: cover property (@(posedge i_clk) $rose(pins_reg.hv_oe));
endmodule

// ===== pfc_flash_model.sv
// Behavioural byte-wide flash as seen at the controller's pins.
// Assumes pfc_pkg pin struct; high voltage shows up as two flags.
`timescale 1ns/10ps
module pfc_flash_model #(
  parameter int ACC_NS = 40,
  parameter logic [7:0] MAKER_ID = 8'h3e, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'hc4 // Arbitrary value
) (
  input wire pfc_pkg::pfc_pins_t i_pins,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_err
);
  // ==========================================
  // Storage and mode
  logic [7:0] mem [0:524287];
  logic [7:0] prot = 8'h00;
  logic id_mode = 1'b0;
  int step = 0;
  int k;
  logic [18:0] wr_addr;
  logic [7:0] rd_val;
  logic [7:0] last_val = 8'h00;
  wire wr_on = !i_pins.ce_n && !i_pins.we_n && i_pins.oe_n && !i_pins.hv_addr;
  wire rd_on = !i_pins.ce_n && !i_pins.oe_n && !i_pins.hv_oe;
  initial begin
    o_err = 1'b0;
    for (k = 0; k < 524288; k++) begin
      mem[k] = 8'hff;
    end
  end
  // ==========================================
  // Command cycles
  always @(posedge wr_on) wr_addr = i_pins.addr;
  always @(negedge wr_on) begin
    if (step != 3 && i_dq == 8'hf0) begin
      id_mode = 1'b0;
      step = 0;
    end else if (step inside {0, 4} && wr_addr[10:0] == 11'h555 && i_dq == 8'haa) begin
      step++;
    end else if (step inside {1, 5} && wr_addr[10:0] == 11'h2aa && i_dq == 8'h55) begin
      step++;
    end else if (step == 2 && i_dq inside {8'h90, 8'ha0, 8'h80}) begin
      id_mode = (i_dq == 8'h90);
      step = (i_dq == 8'ha0) ? 3 : (i_dq == 8'h80) ? 4 : 0;
    end else if (step == 3) begin
      if (!prot[wr_addr[18:16]]) mem[wr_addr] = mem[wr_addr] & i_dq;
      step = 0;
    end else if (step == 6 && i_dq inside {8'h10, 8'h30}) begin
      for (k = 0; k < 524288; k++) begin
        if (!prot[k[18:16]] && (i_dq == 8'h10 || k[18:16] == wr_addr[18:16])) mem[k] = 8'hff;
      end
      step = 0;
    end else if (!(step == 0 && i_dq inside {8'hb0, 8'h30})) begin
      o_err = 1'b1;
      step = 0;
    end
  end
  // ==========================================
  // High-voltage protect and unprotect
  always @(posedge i_pins.we_n) begin
    if (i_pins.hv_addr && i_pins.hv_oe && !i_pins.ce_n) begin
      if (i_pins.addr[6]) prot = 8'h00;
      else prot[i_pins.addr[18:16]] = 1'b1;
    end
  end
  // ==========================================
  // Read path; released pins show the inverse, not a stale byte
  always @* begin
    if (i_pins.hv_addr && i_pins.addr[1]) rd_val = {7'h00, prot[i_pins.addr[18:16]]};
    else if (i_pins.hv_addr || id_mode) rd_val = i_pins.addr[0] ? DEV_ID : MAKER_ID;
    else rd_val = mem[i_pins.addr];
    if (rd_on) last_val = rd_val;
  end
  assign #(ACC_NS) o_dq = rd_on ? rd_val : ~last_val;
endmodule

// ===== tb_parallel_flash_bus_mode_control.sv
// Self-checking bench for the parallel flash host controller.
// Assumes pfc_pkg, pfc_ctrl and pfc_flash_model are compiled first.
`timescale 1ns/10ps
module tb_parallel_flash_bus_mode_control;
  localparam logic [7:0] MAKER_ID = 8'h3e; // Arbitrary value
  localparam logic [7:0] DEV_ID = 8'hc4; // Arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  pfc_pkg::pfc_req_t req = '0;
  logic req_ready, rsp_valid, rsp_fail, cmd_error, host_dq_oe, flash_err;
  logic [7:0] rsp_data, host_dq, flash_dq;
  pfc_pkg::pfc_pins_t pins;
  int err_count = 0;
  int total_checks = 0;
  wire [7:0] dq_bus = host_dq_oe ? host_dq : flash_dq;
  always #2 clk = ~clk;
  pfc_ctrl #(.HV_PULSE_CYC(4), .SUSPEND_CYC(2)) uut (
    .i_clk(clk), .i_nrst(nrst), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_rsp_fail(rsp_fail), .o_cmd_error(cmd_error), .o_pins(pins),
    .i_dq(dq_bus), .o_dq(host_dq), .o_dq_oe(host_dq_oe)
  );
  pfc_flash_model #(.ACC_NS(40), .MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) flash (
    .i_pins(pins), .i_dq(dq_bus), .o_dq(flash_dq), .o_err(flash_err)
  );
  // ==========================================
  // Reporting
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================
  // Pin monitor
  always @(negedge clk) begin
    if (nrst && !pins.we_n && !pins.hv_addr) begin
      check("oe_n in write", pins.oe_n, 1);
      check("ce_n in write", pins.ce_n, 0);
      check("dq_oe in write", host_dq_oe, 1);
    end
    if (nrst && !pins.oe_n) check("dq_oe in read", host_dq_oe, 0);
  end
  // ==========================================
  // Request helpers; each wait is bounded
  task automatic do_op(input pfc_pkg::pfc_op_t op, input logic [18:0] a, input logic [7:0] d,
                       input logic exp_err = 1'b0);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      err_count++;
      end_of_test();
    end
    req = '{op, a, d};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 1000) begin
      err_count++;
      end_of_test();
    end
    check("cmd_error", cmd_error, exp_err);
    @(negedge clk);
  endtask
  task automatic rd_chk(input pfc_pkg::pfc_op_t op, input logic [18:0] a, input logic [7:0] exp);
    do_op(op, a, 8'h00);
    check("rsp_data", rsp_data, exp);
    check("rsp_fail", rsp_fail, exp[5]);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_program();
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h00000, 8'hff);
    do_op(pfc_pkg::PFC_OP_PROG, 19'h10005, 8'h3c);
    do_op(pfc_pkg::PFC_OP_PROG, 19'h7ffff, 8'h5a);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h10005, 8'h3c);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h7ffff, 8'h5a);
  endtask
  task automatic t_protect();
    do_op(pfc_pkg::PFC_OP_HV_UNPROTECT, 19'h00040, 8'h00, 1'b1);
    for (int s = 0; s < 8; s++) begin
      do_op(pfc_pkg::PFC_OP_HV_PROTECT, {s[2:0], 16'h0000}, 8'h00);
    end
    rd_chk(pfc_pkg::PFC_OP_HV_VERIFY, 19'h20000, 8'h01);
    do_op(pfc_pkg::PFC_OP_PROG, 19'h10006, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h10006, 8'hff);
    do_op(pfc_pkg::PFC_OP_SECT_ERASE, 19'h10000, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h10005, 8'h3c);
    do_op(pfc_pkg::PFC_OP_HV_UNPROTECT, 19'h00040, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_HV_VERIFY, 19'h10000, 8'h00);
    do_op(pfc_pkg::PFC_OP_SECT_ERASE, 19'h10000, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h10005, 8'hff);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h7ffff, 8'h5a);
  endtask
  task automatic t_ident();
    do_op(pfc_pkg::PFC_OP_ID_ENTER, 19'h00000, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h00000, MAKER_ID);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h00001, DEV_ID);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h00000, MAKER_ID);
    do_op(pfc_pkg::PFC_OP_RESET, 19'h00000, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h7ffff, 8'h5a);
    rd_chk(pfc_pkg::PFC_OP_HV_ID, 19'h00001, DEV_ID);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h7ffff, 8'h5a);
  endtask
  task automatic t_erase();
    do_op(pfc_pkg::PFC_OP_SECT_ERASE, 19'h70000, 8'h00);
    do_op(pfc_pkg::PFC_OP_SUSPEND, 19'h00000, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h7ffff, 8'hff);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h10005, 8'hff);
    do_op(pfc_pkg::PFC_OP_RESUME, 19'h00000, 8'h00);
    do_op(pfc_pkg::PFC_OP_PROG, 19'h30000, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h30000, 8'h00);
    do_op(pfc_pkg::PFC_OP_CHIP_ERASE, 19'h00000, 8'h00);
    rd_chk(pfc_pkg::PFC_OP_READ, 19'h30000, 8'hff);
    do_op(pfc_pkg::pfc_op_t'(4'hf), 19'h00000, 8'h00, 1'b1);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    t_program();
    t_protect();
    t_ident();
    t_erase();
    check("flash_err", flash_err, 0);
    end_of_test();
  end
endmodule
